/* tca_attach_detect.sv */
// attach-state logic for one usb type-c port, with apb registers
// assumes comparator, vbus and pullup-level inputs synchronous to clk
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module tca_attach_detect #(
  parameter int DEB_CYC = tca_pkg::DEB_CYC, // debounce length in cycles
  parameter int SWAP_TX_CYC = tca_pkg::SWAP_TX_CYC // swap pulldown pulse in cycles
) (
  input wire logic clk, // 250 MHz
  input wire logic rst, // synchronous, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [tca_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped address
  output logic irq, // level interrupt
  input wire logic sink_cmp_a, // pin a below sink threshold
  input wire logic cable_cmp_a, // pin a below cable threshold
  input wire logic swap_cmp_a, // pin a below swap threshold
  input wire logic sink_cmp_b, // pin b below sink threshold
  input wire logic cable_cmp_b, // pin b below cable threshold
  input wire logic swap_cmp_b, // pin b below swap threshold
  input wire logic vbus_present, // vbus above valid level
  input wire logic [1:0] pullup_lvl_a, // partner pullup level on a
  input wire logic [1:0] pullup_lvl_b, // partner pullup level on b
  input wire logic tx_req, // core wants to transmit
  input wire logic tx_data, // bmc line level to send
  output logic [1:0] adv_current, // pullup current and threshold set
  output logic pullup_en_a, // source pullup on a
  output logic pullup_en_b, // source pullup on b
  output logic vbus_en, // vbus source switch
  output logic vconn_en_a, // vconn onto pin a
  output logic vconn_en_b, // vconn onto pin b
  output logic trimmed_sink_pulldown_a, // normal pulldown on a
  output logic trimmed_sink_pulldown_b, // normal pulldown on b
  output logic dead_battery_pulldown_a, // untrimmed pulldown on a
  output logic dead_battery_pulldown_b, // untrimmed pulldown on b
  output logic swap_signal_pulldown_a, // swap pulldown on a
  output logic swap_signal_pulldown_b, // swap pulldown on b
  output logic cc_tx_out_a, // driver level on a
  output logic cc_tx_oe_a, // driver enable on a
  output logic cc_tx_out_b, // driver level on b
  output logic cc_tx_oe_b, // driver enable on b
  output logic fast_role_swap_evt // swap detected, one-cycle pulse
);
  localparam int CW = $clog2(DEB_CYC + 1);
  localparam int FW = $clog2(SWAP_TX_CYC + 1);

  logic [31:0] ctrl;
  logic [31:0] status;
  logic [tca_pkg::INT_W-1:0] int_st;
  logic [tca_pkg::INT_W-1:0] int_mask;
  logic [tca_pkg::INT_W-1:0] int_set;
  logic src;
  logic db_act;
  logic conn_b;
  logic swap_b;
  logic att;
  logic att_q;
  logic [1:0] partner_cur;
  logic [FW-1:0] swap_cnt;
  logic [3:0] raw;
  logic [3:0] deb;
  logic sk_a;
  logic ca_a;
  logic sk_b;
  logic ca_b;
  logic wr;
  logic rd;
  logic hit;
  logic ctrl_wr;
  logic rd_int;
  logic swap_hit;
  logic swap_go;
  logic ufp;
  tca_pkg::tca_state_e state;
  tca_pkg::tca_state_e next_state;
  tca_pkg::tca_pin_e pa;
  tca_pkg::tca_pin_e pb;

  // apb slave: zero wait states, read data latched in the setup cycle
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign hit = (paddr == tca_pkg::OFF_CTRL) || (paddr == tca_pkg::OFF_STATUS) ||
               (paddr == tca_pkg::OFF_INT) || (paddr == tca_pkg::OFF_MASK);
  assign ctrl_wr = wr & (paddr == tca_pkg::OFF_CTRL);
  assign rd_int = rd & (paddr == tca_pkg::OFF_INT);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign irq = |(int_st & int_mask);

  always_comb begin
    status = '0;
    status[tca_pkg::S_STATE +: tca_pkg::S_STATE_W] = state;
    status[tca_pkg::S_PCUR +: 2] = partner_cur;
    status[tca_pkg::S_SRC] = src;
    status[tca_pkg::S_VBUS] = vbus_en;
    status[tca_pkg::S_VCONN_A] = vconn_en_a;
    status[tca_pkg::S_VCONN_B] = vconn_en_b;
    status[tca_pkg::S_DB] = db_act;
    status[tca_pkg::S_CONN_B] = conn_b;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        tca_pkg::OFF_CTRL: prdata <= ctrl;
        tca_pkg::OFF_STATUS: prdata <= status;
        tca_pkg::OFF_INT: prdata <= {{(32 - tca_pkg::INT_W){1'b0}}, int_st};
        tca_pkg::OFF_MASK: prdata <= {{(32 - tca_pkg::INT_W){1'b0}}, int_mask};
        default: prdata <= '0;
      endcase
    end
  end

  // action bits (swap send, pulldown release) are not stored
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= tca_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl <= pwdata & tca_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_mask <= tca_pkg::MASK_RST;
    end else if (wr && paddr == tca_pkg::OFF_MASK) begin
      int_mask <= pwdata[tca_pkg::INT_W-1:0];
    end
  end

  // read clears, a new event in the same cycle stays set
  always_ff @(posedge clk) begin
    if (rst) begin
      int_st <= '0;
    end else begin
      int_st <= (int_st & ~{tca_pkg::INT_W{rd_int}}) | int_set;
    end
  end

  always_comb begin
    int_set = '0;
    int_set[tca_pkg::I_ATTACH] = att & ~att_q;
    int_set[tca_pkg::I_DETACH] = ~att & att_q;
    int_set[tca_pkg::I_SWAP_DET] = swap_hit;
    int_set[tca_pkg::I_SWAP_SENT] = swap_go;
  end

  // reserved current code behaves as high
  assign adv_current = (ctrl[tca_pkg::C_CUR +: 2] == tca_pkg::CUR_RSVD) ?
                       tca_pkg::CUR_HIGH : ctrl[tca_pkg::C_CUR +: 2];

  // comparator debounce, one filter per sink and cable comparator; the swap comparators are not filtered
  assign raw = {cable_cmp_b, sink_cmp_b, cable_cmp_a, sink_cmp_a};
  for (genvar i = 0; i < 4; i++) begin : g_deb
    logic [CW-1:0] cnt;
    logic d;
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt <= '0;
        d <= 1'b0;
      end else if (raw[i] == d) begin
        cnt <= '0;
      end else if (cnt == CW'(DEB_CYC - 1)) begin
        cnt <= '0;
        d <= raw[i];
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
    assign deb[i] = d;
  end
  assign sk_a = deb[0];
  assign ca_a = deb[1];
  assign sk_b = deb[2];
  assign ca_b = deb[3];

  function automatic tca_pkg::tca_pin_e pin_cls(input logic snk, input logic cab);
    if (cab) begin
      return tca_pkg::PIN_RA;
    end
    if (snk) begin
      return tca_pkg::PIN_RD;
    end
    return tca_pkg::PIN_OPEN;
  endfunction

  assign pa = pin_cls(sk_a, ca_a);
  assign pb = pin_cls(sk_b, ca_b);

  function automatic tca_pkg::tca_state_e entry(input tca_pkg::tca_pin_e a,
                                                input tca_pkg::tca_pin_e b);
    tca_pkg::tca_state_e s;
    s = tca_pkg::ST_OPEN;
    if (a == tca_pkg::PIN_RD && b == tca_pkg::PIN_OPEN) s = tca_pkg::ST_RD_A;
    if (a == tca_pkg::PIN_OPEN && b == tca_pkg::PIN_RD) s = tca_pkg::ST_RD_B;
    if (a == tca_pkg::PIN_RA && b == tca_pkg::PIN_OPEN) s = tca_pkg::ST_RA_A;
    if (a == tca_pkg::PIN_OPEN && b == tca_pkg::PIN_RA) s = tca_pkg::ST_RA_B;
    if (a == tca_pkg::PIN_RA && b == tca_pkg::PIN_RD) s = tca_pkg::ST_RA_A_RD_B;
    if (a == tca_pkg::PIN_RD && b == tca_pkg::PIN_RA) s = tca_pkg::ST_RD_A_RA_B;
    if (a == tca_pkg::PIN_RD && b == tca_pkg::PIN_RD) s = tca_pkg::ST_DEBUG;
    if (a == tca_pkg::PIN_RA && b == tca_pkg::PIN_RA) s = tca_pkg::ST_AUDIO;
    return s;
  endfunction

  assign ufp = (state == tca_pkg::ST_UFP_IDLE) || (state == tca_pkg::ST_UFP_ATT);

  always_comb begin
    next_state = state;
    if (src && ufp) begin
      next_state = tca_pkg::ST_OPEN;
    end else if (!src && !ufp) begin
      next_state = tca_pkg::ST_UFP_IDLE;
    end else begin
      unique case (state)
        tca_pkg::ST_OPEN: next_state = entry(pa, pb);
        tca_pkg::ST_RD_A: if (!sk_a) next_state = tca_pkg::ST_OPEN;
        tca_pkg::ST_RD_B: if (!sk_b) next_state = tca_pkg::ST_OPEN;
        tca_pkg::ST_RA_A: begin
          if (pa != tca_pkg::PIN_RA) begin
            next_state = tca_pkg::ST_OPEN;
          end else if (pb == tca_pkg::PIN_RD) begin
            next_state = tca_pkg::ST_RA_A_RD_B;
          end
        end
        tca_pkg::ST_RA_B: begin
          if (pb != tca_pkg::PIN_RA) begin
            next_state = tca_pkg::ST_OPEN;
          end else if (pa == tca_pkg::PIN_RD) begin
            next_state = tca_pkg::ST_RD_A_RA_B;
          end
        end
        tca_pkg::ST_RA_A_RD_B: if (!sk_b) next_state = tca_pkg::ST_OPEN;
        tca_pkg::ST_RD_A_RA_B: if (!sk_a) next_state = tca_pkg::ST_OPEN;
        tca_pkg::ST_DEBUG: if (!sk_a || !sk_b) next_state = tca_pkg::ST_OPEN;
        tca_pkg::ST_AUDIO: begin
          if (pa != tca_pkg::PIN_RA || pb != tca_pkg::PIN_RA) begin
            next_state = tca_pkg::ST_OPEN;
          end
        end
        tca_pkg::ST_UFP_IDLE: if (vbus_present) next_state = tca_pkg::ST_UFP_ATT;
        tca_pkg::ST_UFP_ATT: if (!vbus_present) next_state = tca_pkg::ST_UFP_IDLE;
        default: next_state = tca_pkg::ST_UFP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= tca_pkg::ST_UFP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // power switches follow the state being entered
  always_ff @(posedge clk) begin
    if (rst) begin
      vbus_en <= 1'b0;
      vconn_en_a <= 1'b0;
      vconn_en_b <= 1'b0;
    end else begin
      vbus_en <= next_state inside {tca_pkg::ST_RD_A, tca_pkg::ST_RD_B,
                 tca_pkg::ST_RA_A_RD_B, tca_pkg::ST_RD_A_RA_B};
      vconn_en_a <= next_state == tca_pkg::ST_RA_A_RD_B;
      vconn_en_b <= next_state == tca_pkg::ST_RD_A_RA_B;
    end
  end

  // connected pin and partner current
  always_ff @(posedge clk) begin
    if (rst) begin
      conn_b <= 1'b0;
      partner_cur <= tca_pkg::PU_NONE;
    end else begin
      unique case (next_state)
        tca_pkg::ST_RD_B, tca_pkg::ST_RA_A_RD_B: conn_b <= 1'b1;
        tca_pkg::ST_RD_A, tca_pkg::ST_RD_A_RA_B: conn_b <= 1'b0;
        tca_pkg::ST_UFP_ATT: conn_b <= pullup_lvl_a == tca_pkg::PU_NONE;
        default: conn_b <= conn_b;
      endcase
      if (next_state == tca_pkg::ST_UFP_ATT) begin
        partner_cur <= (pullup_lvl_a != tca_pkg::PU_NONE) ?
                       pullup_lvl_a : pullup_lvl_b;
      end else begin
        partner_cur <= tca_pkg::PU_NONE;
      end
    end
  end

  assign att = !(state inside {tca_pkg::ST_OPEN, tca_pkg::ST_RA_A, tca_pkg::ST_RA_B,
                 tca_pkg::ST_UFP_IDLE});
  always_ff @(posedge clk) begin
    if (rst) begin
      att_q <= 1'b0;
    end else begin
      att_q <= att;
    end
  end

  // fast role swap in both directions
  assign swap_hit = ~src & ctrl[tca_pkg::C_SWAP_EN] & (state == tca_pkg::ST_UFP_ATT) &
                    (conn_b ? swap_cmp_b : swap_cmp_a);
  assign swap_go = ctrl_wr & pwdata[tca_pkg::C_SWAP_SEND] & ctrl[tca_pkg::C_SWAP_EN] &
                   src & vbus_en;

  always_ff @(posedge clk) begin
    if (rst) begin
      src <= 1'b0;
    end else if (swap_hit) begin
      src <= 1'b1;
    end else if (swap_go) begin
      src <= 1'b0;
    end else if (ctrl_wr) begin
      src <= pwdata[tca_pkg::C_ROLE];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fast_role_swap_evt <= 1'b0;
      swap_cnt <= '0;
      swap_b <= 1'b0;
    end else begin
      fast_role_swap_evt <= swap_hit;
      if (swap_go) begin
        swap_cnt <= FW'(SWAP_TX_CYC);
        swap_b <= conn_b;
      end else if (swap_cnt != '0) begin
        swap_cnt <= swap_cnt - 1'b1;
      end
    end
  end
  assign swap_signal_pulldown_a = (swap_cnt != '0) & ~swap_b;
  assign swap_signal_pulldown_b = (swap_cnt != '0) & swap_b;

  // dead-battery pulldown stays in the sink role until software releases it
  always_ff @(posedge clk) begin
    if (rst) begin
      db_act <= 1'b1;
    end else if (ctrl_wr && pwdata[tca_pkg::C_DB_REL]) begin
      db_act <= 1'b0;
    end
  end
  assign dead_battery_pulldown_a = ~src & db_act;
  assign dead_battery_pulldown_b = ~src & db_act;
  assign trimmed_sink_pulldown_a = ~src & ~db_act;
  assign trimmed_sink_pulldown_b = ~src & ~db_act;
  assign pullup_en_a = src & ~vconn_en_a;
  assign pullup_en_b = src & ~vconn_en_b;

  // driver enabled only on the connected pin while attached and not swapping
  always_ff @(posedge clk) begin
    if (rst) begin
      cc_tx_oe_a <= 1'b0;
      cc_tx_oe_b <= 1'b0;
      cc_tx_out_a <= 1'b0;
      cc_tx_out_b <= 1'b0;
    end else begin
      // the send strobe also blocks, else the driver and swap pulldown overlap a cycle
      cc_tx_oe_a <= ctrl[tca_pkg::C_TX_EN] & tx_req & att & ~conn_b &
                    (swap_cnt == '0) & ~swap_go;
      cc_tx_oe_b <= ctrl[tca_pkg::C_TX_EN] & tx_req & att & conn_b &
                    (swap_cnt == '0) & ~swap_go;
      cc_tx_out_a <= tx_data;
      cc_tx_out_b <= tx_data;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_idle_off;
    (state == tca_pkg::ST_OPEN) |-> !vbus_en && !vconn_en_a && !vconn_en_b;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("power on while open");

  property p_detach_a;
    (state == tca_pkg::ST_RD_A && !sk_a) |=> !vbus_en;
  endproperty
  a_detach_a: assert property (p_detach_a) else $error("vbus kept after detach");

  property p_cable_sink;
    (src && state == tca_pkg::ST_RA_A && pa == tca_pkg::PIN_RA && pb == tca_pkg::PIN_RD &&
     !ctrl_wr) |=> vbus_en && vconn_en_a && !vconn_en_b;
  endproperty
  a_cable_sink: assert property (p_cable_sink) else $error("vconn not on a");

  property p_vconn_b;
    vconn_en_b |-> vbus_en && !conn_b && !vconn_en_a;
  endproperty
  a_vconn_b: assert property (p_vconn_b) else $error("vconn b inconsistent");

  property p_debug_exit;
    (src && state == tca_pkg::ST_DEBUG && !sk_b && !ctrl_wr) |=> state == tca_pkg::ST_OPEN;
  endproperty
  a_debug_exit: assert property (p_debug_exit) else $error("debug detach missed");

  property p_debounce;
    $changed(deb[0]) |-> $past(raw[0] != deb[0], 1) && $past(raw[0] != deb[0], 2);
  endproperty
  a_debounce: assert property (p_debounce) else $error("glitch passed filter");

  property p_swap_sink;
    swap_hit |=> src && fast_role_swap_evt ##1 !fast_role_swap_evt;
  endproperty
  a_swap_sink: assert property (p_swap_sink) else $error("swap not taken");

  property p_swap_src;
    swap_go |=> !src && (swap_signal_pulldown_a || swap_signal_pulldown_b);
  endproperty
  a_swap_src: assert property (p_swap_src) else $error("swap not signalled");

  property p_db;
    dead_battery_pulldown_a |-> !trimmed_sink_pulldown_a && !src && db_act;
  endproperty
  a_db: assert property (p_db) else $error("both pulldowns on");

  property p_one_driver;
    cc_tx_oe_a |-> !cc_tx_oe_b && !swap_signal_pulldown_a;
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("two drivers on");

  property p_ufp_attach;
    (state == tca_pkg::ST_UFP_IDLE && vbus_present && !src && !ctrl_wr && !swap_hit)
      |=> state == tca_pkg::ST_UFP_ATT;
  endproperty
  a_ufp_attach: assert property (p_ufp_attach) else $error("vbus attach missed");

endmodule // tca_attach_detect
`default_nettype wire

/* tca_partner_model.sv */
// port partner and cable model for the attach detector bench
// assumes the bench sets pin terminations and the partner role
`timescale 1ns/10ps
`default_nettype none
module tca_partner_model (
  input wire tca_pkg::tca_pin_e term_a, // termination on pin a
  input wire tca_pkg::tca_pin_e term_b, // termination on pin b
  input wire logic src_on, // partner sources vbus
  input wire logic [1:0] lvl, // partner pullup level
  input wire logic swap_req, // partner pulls pin a below swap level
  input wire logic tx_req, // partner wants the wire
  input wire logic dut_oe_a, // design drives pin a
  input wire logic dut_oe_b, // design drives pin b
  output logic sink_cmp_a, // pin a below sink level
  output logic cable_cmp_a, // pin a below cable level
  output logic swap_cmp_a, // pin a below swap level
  output logic sink_cmp_b, // pin b below sink level
  output logic cable_cmp_b, // pin b below cable level
  output logic swap_cmp_b, // pin b below swap level
  output logic vbus_present, // partner vbus
  output logic [1:0] pullup_lvl_a, // pullup seen on a
  output logic [1:0] pullup_lvl_b, // pullup seen on b
  output logic tx_oe // partner driver enable
);
  // a sink or cable pulldown both pull the pin below the sink level
  assign sink_cmp_a = term_a != tca_pkg::PIN_OPEN;
  assign sink_cmp_b = term_b != tca_pkg::PIN_OPEN;
  assign cable_cmp_a = term_a == tca_pkg::PIN_RA;
  assign cable_cmp_b = term_b == tca_pkg::PIN_RA;
  assign swap_cmp_a = swap_req;
  assign swap_cmp_b = 1'b0;
  assign vbus_present = src_on;
  assign pullup_lvl_a = src_on ? lvl : 2'h0;
  assign pullup_lvl_b = 2'h0;
  assign tx_oe = tx_req & !dut_oe_a & !dut_oe_b;
endmodule // tca_partner_model
`default_nettype wire

/* tca_pkg.sv */
// constants, register map and state codes for the type-c attach detector
// assumes one 250 MHz clock and an apb master with 32-bit data
`default_nettype none
package tca_pkg;
  localparam int CLK_NS = 4;
  localparam int DEB_NS = 10000;
  localparam int DEB_CYC = (DEB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SWAP_TX_NS = 100000;
  localparam int SWAP_TX_CYC = (SWAP_TX_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_INT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam int C_ROLE = 0;
  localparam int C_CUR = 1;
  localparam int C_SWAP_EN = 3;
  localparam int C_SWAP_SEND = 4;
  localparam int C_DB_REL = 5;
  localparam int C_TX_EN = 6;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] CTRL_MASK = 32'h0000004F;
  localparam int S_STATE = 0;
  localparam int S_STATE_W = 4;
  localparam int S_PCUR = 4;
  localparam int S_SRC = 6;
  localparam int S_VBUS = 7;
  localparam int S_VCONN_A = 8;
  localparam int S_VCONN_B = 9;
  localparam int S_DB = 10;
  localparam int S_CONN_B = 11;
  localparam int INT_W = 4;
  localparam int I_ATTACH = 0;
  localparam int I_DETACH = 1;
  localparam int I_SWAP_DET = 2;
  localparam int I_SWAP_SENT = 3;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] CUR_DEF = 2'h0;
  localparam logic [1:0] CUR_MED = 2'h1;
  localparam logic [1:0] CUR_HIGH = 2'h2;
  localparam logic [1:0] CUR_RSVD = 2'h3;
  localparam logic [1:0] PU_NONE = 2'h0;
  typedef enum logic [3:0] {
    ST_OPEN, ST_RD_A, ST_RD_B, ST_RA_A, ST_RA_B, ST_RA_A_RD_B, ST_RD_A_RA_B,
    ST_DEBUG, ST_AUDIO, ST_UFP_IDLE, ST_UFP_ATT
  } tca_state_e;
  typedef enum logic [1:0] {PIN_OPEN, PIN_RD, PIN_RA} tca_pin_e;
endpackage
`default_nettype wire

/* typec_cc_attach_detect_tb_top.sv */
// self-checking bench for the type-c attach detector
// assumes tca_pkg and a 250 MHz clock; debounce and swap pulse shortened
`timescale 1ns/10ps
`default_nettype none
module typec_cc_attach_detect_tb_top;
  localparam int DEB = 4;
  localparam int SWP_CYC = 8;
  localparam int SETTLE = DEB + 8;
  localparam logic [7:0] AC = tca_pkg::OFF_CTRL;
  localparam logic [7:0] AS = tca_pkg::OFF_STATUS;
  localparam logic [7:0] AI = tca_pkg::OFF_INT;
  localparam logic [7:0] AM = tca_pkg::OFF_MASK;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_req = 1'b0, tx_data = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, vbus_present, fast_role_swap_evt, d;
  logic sink_cmp_a, cable_cmp_a, swap_cmp_a, sink_cmp_b, cable_cmp_b, swap_cmp_b;
  logic [1:0] pullup_lvl_a, pullup_lvl_b, adv_current;
  logic [1:0] lvl = 2'h0;
  logic pullup_en_a, pullup_en_b, vbus_en, vconn_en_a, vconn_en_b;
  logic trimmed_sink_pulldown_a, trimmed_sink_pulldown_b;
  logic dead_battery_pulldown_a, dead_battery_pulldown_b;
  logic swap_signal_pulldown_a, swap_signal_pulldown_b;
  logic cc_tx_out_a, cc_tx_oe_a, cc_tx_out_b, cc_tx_oe_b;
  logic src_on = 1'b0, swap_req = 1'b0, p_tx_req = 1'b0, p_tx_oe;
  tca_pkg::tca_pin_e term_a = tca_pkg::PIN_OPEN, term_b = tca_pkg::PIN_OPEN;
  int err_count = 0, tests_run = 0, evt_cnt = 0;
  logic [63:0] rq[$];
  logic [63:0] e;
  logic [11:0] row;
  // per row: pin a, pin b, state, vbus, vconn a, vconn b
  logic [11:0] tbl [9] = '{12'h000, 12'h414, 12'h124, 12'h830, 12'h240,
                           12'h956, 12'h665, 12'h570, 12'hA80};

  tca_attach_detect #(.DEB_CYC(DEB), .SWAP_TX_CYC(SWP_CYC)) tca_attach_detect_i (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .sink_cmp_a, .cable_cmp_a, .swap_cmp_a, .sink_cmp_b,
    .cable_cmp_b, .swap_cmp_b, .vbus_present, .pullup_lvl_a, .pullup_lvl_b,
    .tx_req, .tx_data, .adv_current, .pullup_en_a, .pullup_en_b, .vbus_en,
    .vconn_en_a, .vconn_en_b, .trimmed_sink_pulldown_a, .trimmed_sink_pulldown_b,
    .dead_battery_pulldown_a, .dead_battery_pulldown_b, .swap_signal_pulldown_a,
    .swap_signal_pulldown_b, .cc_tx_out_a, .cc_tx_oe_a, .cc_tx_out_b,
    .cc_tx_oe_b, .fast_role_swap_evt);

  tca_partner_model tca_partner_model_i (
    .term_a, .term_b, .src_on, .lvl, .swap_req, .tx_req(p_tx_req),
    .dut_oe_a(cc_tx_oe_a), .dut_oe_b(cc_tx_oe_b), .sink_cmp_a, .cable_cmp_a,
    .swap_cmp_a, .sink_cmp_b, .cable_cmp_b, .swap_cmp_b, .vbus_present,
    .pullup_lvl_a, .pullup_lvl_b, .tx_oe(p_tx_oe));

  always #2 clk = ~clk;

  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] s);
    tests_run++;
    if (s !== ex) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, ex, s);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // for a read, dat is the expected word under mask m
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat,
                     input logic [31:0] m);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    if (!w) rq.push_back({m, dat & m});
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    chk("pslverr", {31'h0, a > AM}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read results are compared at the access edge against the oldest note
  always @(posedge clk) begin
    if (fast_role_swap_evt === 1'b1) evt_cnt <= evt_cnt + 1;
    if (psel && penable && !pwrite && pready === 1'b1) begin
      e = rq.pop_front();
      chk("prdata", e[31:0], prdata & e[63:32]);
    end
  end

  task automatic results;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    wt(30000);
    err_count++;
    results;
  end

  initial begin
    void'($urandom(32'hCA29));
    wt(20);
    rst <= 1'b0;
    wt(2);
    chk("db_pd_a", 1, dead_battery_pulldown_a);
    chk("trim_pd_b", 0, trimmed_sink_pulldown_b);
    apb(0, AS, 32'h409, 32'hFFF);
    r = $urandom & 32'hF;
    apb(1, AM, r, 0);
    apb(0, AM, r, 32'hF);
    apb(1, AM, 32'hF, 0);
    apb(0, 8'h10, 32'h0, 32'hFFFFFFFF);
    src_on <= 1'b1;
    lvl <= 2'h2;
    wt(SETTLE);
    apb(0, AS, 32'h42A, 32'hFFF);
    chk("irq", 1, irq);
    apb(0, AI, 32'h1, 32'hF);
    wt(1);
    chk("irq_clr", 0, irq);
    apb(1, AC, 32'h20, 0);
    wt(1);
    chk("trim_pd_a", 1, trimmed_sink_pulldown_a);
    chk("trim_pd_b", 1, trimmed_sink_pulldown_b);
    chk("db_pd_a", 0, dead_battery_pulldown_a);
    apb(1, AC, 32'h8, 0);
    swap_req <= 1'b1;
    wt(4);
    swap_req <= 1'b0;
    src_on <= 1'b0;
    lvl <= 2'h0;
    chk("swap_evt", 1, evt_cnt);
    apb(0, AS, 32'h40, 32'h40);
    apb(0, AI, 32'h4, 32'h4);
    for (int i = 0; i < 9; i++) begin
      row = tbl[i];
      apb(1, AC, {29'h0, 2'(i % 3), 1'b1}, 0);
      term_a <= tca_pkg::tca_pin_e'(row[11:10]);
      term_b <= tca_pkg::tca_pin_e'(row[9:8]);
      wt(SETTLE);
      chk("adv_current", i % 3, {30'h0, adv_current});
      chk("vbus_en", row[2], vbus_en);
      chk("vconn_a", row[1], vconn_en_a);
      chk("vconn_b", row[0], vconn_en_b);
      chk("pullup_a", {31'h0, ~row[1]}, pullup_en_a);
      chk("pullup_b", {31'h0, ~row[0]}, pullup_en_b);
      apb(0, AS, {28'h0, row[7:4]}, 32'hF);
      if (i == 3) begin
        // sink joins behind a powered cable already seen on a
        term_b <= tca_pkg::PIN_RD;
        wt(SETTLE);
        chk("cable_vconn_a", 1, vconn_en_a);
        chk("cable_vbus", 1, vbus_en);
      end
      if (i == 5) begin
        term_a <= tca_pkg::PIN_OPEN;
        wt(SETTLE);
        chk("vbus_kept", 1, vbus_en);
      end
      term_a <= tca_pkg::PIN_OPEN;
      term_b <= tca_pkg::PIN_OPEN;
      wt(SETTLE);
      chk("vbus_off", 0, vbus_en);
    end
    term_a <= tca_pkg::PIN_RD;
    wt(SETTLE);
    d = 1'($urandom);
    apb(1, AC, 32'h41, 0);
    tx_req <= 1'b1;
    tx_data <= d;
    p_tx_req <= 1'b1;
    wt(3);
    chk("oe_a", 1, cc_tx_oe_a);
    chk("oe_b", 0, cc_tx_oe_b);
    chk("out_a", {31'h0, d}, cc_tx_out_a);
    chk("out_b", {31'h0, d}, cc_tx_out_b);
    chk("partner_oe", 0, p_tx_oe);
    tx_req <= 1'b0;
    p_tx_req <= 1'b0;
    wt(3);
    chk("oe_a_off", 0, cc_tx_oe_a);
    // the send strobe needs the swap enable already stored
    apb(1, AC, 32'h9, 0);
    apb(1, AC, 32'h19, 0);
    wt(2);
    chk("swap_pd_a", 1, swap_signal_pulldown_a);
    chk("swap_pd_b", 0, swap_signal_pulldown_b);
    wt(SWP_CYC + 2);
    chk("swap_pd_end", 0, swap_signal_pulldown_a);
    apb(0, AS, 32'h0, 32'h40);
    apb(0, AI, 32'h8, 32'h8);
    results;
  end
endmodule // typec_cc_attach_detect_tb_top
`default_nettype wire
